// ### design/srsp_defs.svh
// constants for the safety response configuration registers
`ifndef SRSP_DEFS_SVH
`define SRSP_DEFS_SVH

// register select codes on the command port
`define SRSP_SEL_A 1'h0
`define SRSP_SEL_B 1'h1

// register a field positions
`define SRSP_A_CLK_WARN 7
`define SRSP_A_SCHED 5
`define SRSP_A_ST_DIS 4
`define SRSP_A_ST_FAIL 3
`define SRSP_A_DRV_ERR 2
`define SRSP_A_RES_RST 1
`define SRSP_A_RES_SAFE 0

// register b field positions
`define SRSP_B_SSM 6
`define SRSP_B_SPI_CRC 4
`define SRSP_B_WD_MODE 3
`define SRSP_B_ESM_MODE 2
`define SRSP_B_WD_RST 1
`define SRSP_B_ESM_RST 0

// reset values, writable masks, reserved masks
`define SRSP_A_RST 8'h00
`define SRSP_B_RST 8'h02
`define SRSP_A_WMASK 8'hbf
`define SRSP_B_WMASK 8'h5f
`define SRSP_A_RSVD 8'h40
`define SRSP_B_RSVD 8'ha0
// bits of register b set back on each reset-state entry
`define SRSP_B_REINIT 8'h0f

`endif

// ### design/srsp_pkg.sv
// types shared by the safety response configuration logic
package srsp_pkg;

   // operating state of the device as seen by this block
   typedef enum logic [1:0] {
      SRSP_ST_RESET = 2'b00,
      SRSP_ST_DIAG = 2'b01,
      SRSP_ST_ACTIVE = 2'b10,
      SRSP_ST_SAFE = 2'b11
   } srsp_state_t;

endpackage : srsp_pkg

// ### design/srsp_resp_if.sv
// carrier between the register file and the transition decider
interface srsp_resp_if;
   import srsp_pkg::*;

   srsp_state_t state; // current device state
   logic [7:0] cfg_a; // response enables
   logic [7:0] cfg_b; // mode and selector bits
   logic analog_self_test_fail; // analog self-test failure
   logic endrv_err; // enable/interrupt driver fault
   logic reset_output_pin_err; // reset pin driver fault
   logic wd_fail_th; // watchdog counter at threshold
   logic esm_fail_th; // error monitor counter at threshold
   logic safe_req; // decided move to safe
   logic reset_req; // decided move to reset

   modport regs (output state, cfg_a, cfg_b, analog_self_test_fail, endrv_err, reset_output_pin_err,
                 wd_fail_th, esm_fail_th, input safe_req, reset_req);
   modport dec (input state, cfg_a, cfg_b, analog_self_test_fail, endrv_err, reset_output_pin_err,
                wd_fail_th, esm_fail_th, output safe_req, reset_req);
endinterface : srsp_resp_if

// ### design/srsp_decide.sv
// decides state transition requests from fault events and config bits
`include "srsp_defs.svh"
module srsp_decide import srsp_pkg::*; (
   srsp_resp_if.dec rif
);

   logic diag_act; // in diagnostic or active
   logic not_rst; // in diagnostic, active or safe

   ////////////////////////////////////////////////////////////////////////
   // combinational decision, reset outranks safe
   always_comb begin
      diag_act = (rif.state == SRSP_ST_DIAG) || (rif.state == SRSP_ST_ACTIVE);
      not_rst = (rif.state != SRSP_ST_RESET);
      rif.reset_req = 1'b0;
      rif.safe_req = 1'b0;
      // reset pin fault to reset
      if (rif.reset_output_pin_err && rif.cfg_a[`SRSP_A_RES_RST] && not_rst) begin
         rif.reset_req = 1'b1;
      end
      // watchdog threshold, selector masked to reset while safe
      if (rif.wd_fail_th) begin
         if (rif.state == SRSP_ST_SAFE) begin
            rif.reset_req = 1'b1;
         end else if (diag_act && rif.cfg_b[`SRSP_B_WD_RST]) begin
            rif.reset_req = 1'b1;
         end else if (diag_act) begin
            rif.safe_req = 1'b1;
         end
      end
      // error monitor threshold
      if (rif.esm_fail_th && not_rst && rif.cfg_b[`SRSP_B_ESM_RST]) begin
         rif.reset_req = 1'b1;
      end else if (rif.esm_fail_th && diag_act) begin
         rif.safe_req = 1'b1;
      end
      // safe causes from diagnostic or active
      if (diag_act && rif.analog_self_test_fail && rif.cfg_a[`SRSP_A_ST_FAIL]) begin
         rif.safe_req = 1'b1;
      end
      if (diag_act && rif.endrv_err && rif.cfg_a[`SRSP_A_DRV_ERR]) begin
         rif.safe_req = 1'b1;
      end
      if (diag_act && rif.reset_output_pin_err && rif.cfg_a[`SRSP_A_RES_SAFE]) begin
         rif.safe_req = 1'b1;
      end
      // reset wins when both are asked
      if (rif.reset_req) begin
         rif.safe_req = 1'b0;
      end
   end

endmodule // srsp_decide

// ### design/srsp_regs.sv
// safety response configuration registers with command port and responses
//
// What this block does
// - auto self-tests at reset entry unless disabled
// - self-test failure moves to safe when enabled
// - driver fault moves to safe when enabled
// - reset pin fault moves to reset when enabled
// - reset pin fault moves to safe when enabled
// - reset pin fault: reset outranks safe
// - writes only in diagnostic, unlocked; checksum covered
// - spread spectrum on when bit set, default off
// - spi frame crc on when bit set
// - watchdog answer mode, reinit on reset entry
// - error monitor mode, reinit on reset entry
// - watchdog threshold goes reset or safe per bit
// - error monitor threshold goes reset or safe
`include "srsp_defs.svh"
module srsp_regs import srsp_pkg::*; (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // register commands from the controller
   input wire logic cmd_valid_i,
   input wire logic cmd_write_i,
   input wire logic cmd_sel_i,
   input wire logic [7:0] cmd_wdata_i,
   // command answers
   output logic rsp_valid_o,
   output logic [7:0] rsp_rdata_o,
   output logic rsp_refused_o,
   // device state
   input wire srsp_state_t dev_state_i,
   input wire logic cfg_lock_i,
   input wire logic reset_entry_i,
   // fault events
   input wire logic analog_self_test_fail_i,
   input wire logic endrv_err_i,
   input wire logic reset_output_pin_err_i,
   input wire logic wd_fail_th_i,
   input wire logic esm_fail_th_i,
   // transition requests and self-test start
   output logic go_safe_o,
   output logic go_reset_o,
   output logic self_test_run_o,
   // configuration to the rest of the device
   output logic spread_spectrum_enable_o,
   output logic spi_crc_enable_o,
   output logic watchdog_answer_mode_o,
   output logic error_monitor_mode_o,
   output logic [15:0] crc_image_o
);

   logic [7:0] cfg_a_r, cfg_a_nxt; // response enables
   logic [7:0] cfg_b_r, cfg_b_nxt; // modes and selectors
   logic rsp_valid_r, rsp_valid_nxt; // answer strobe
   logic [7:0] rsp_rdata_r, rsp_rdata_nxt; // answer data
   logic rsp_ref_r, rsp_ref_nxt; // write refused
   logic safe_r, safe_nxt; // safe request
   logic rst_r, rst_nxt; // reset request
   logic st_run_r, st_run_nxt; // self-test start
   logic ssm_r, crc_r, wdm_r, esm_r; // mirrored config outputs
   logic wr_ok; // write allowed now

   srsp_resp_if rif ();

   ////////////////////////////////////////////////////////////////////////
   // decider hookup
   assign rif.state = dev_state_i;
   assign rif.cfg_a = cfg_a_r;
   assign rif.cfg_b = cfg_b_r;
   assign rif.analog_self_test_fail = analog_self_test_fail_i;
   assign rif.endrv_err = endrv_err_i;
   assign rif.reset_output_pin_err = reset_output_pin_err_i;
   assign rif.wd_fail_th = wd_fail_th_i;
   assign rif.esm_fail_th = esm_fail_th_i;

   srsp_decide u_dec (
      .rif (rif.dec)
   );

   ////////////////////////////////////////////////////////////////////////
   // next values of registers and answers
   always_comb begin
      wr_ok = (dev_state_i == SRSP_ST_DIAG) && !cfg_lock_i;
      cfg_a_nxt = cfg_a_r;
      cfg_b_nxt = cfg_b_r;
      rsp_valid_nxt = cmd_valid_i;
      rsp_ref_nxt = 1'b0;
      // accepted write, reserved bits held at zero
      if (cmd_valid_i && cmd_write_i && wr_ok) begin
         if (cmd_sel_i == `SRSP_SEL_A) begin
            cfg_a_nxt = cmd_wdata_i & `SRSP_A_WMASK;
         end else begin
            cfg_b_nxt = cmd_wdata_i & `SRSP_B_WMASK;
         end
      end else if (cmd_valid_i && cmd_write_i) begin
         rsp_ref_nxt = 1'b1;
      end
      // reset entry restores the mode and selector bits
      if (reset_entry_i) begin
         cfg_b_nxt = (cfg_b_nxt & ~`SRSP_B_REINIT) | (`SRSP_B_RST & `SRSP_B_REINIT);
      end
      // answer shows the register after the command
      if (cmd_sel_i == `SRSP_SEL_A) begin
         rsp_rdata_nxt = cfg_a_nxt;
      end else begin
         rsp_rdata_nxt = cfg_b_nxt;
      end
      // self-tests run during reset extension unless disabled
      st_run_nxt = reset_entry_i && !cfg_a_r[`SRSP_A_ST_DIS];
      safe_nxt = rif.safe_req;
      rst_nxt = rif.reset_req;
   end

   ////////////////////////////////////////////////////////////////////////
   // registers, synchronous active-low reset
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         cfg_a_r <= `SRSP_A_RST;
         cfg_b_r <= `SRSP_B_RST;
         rsp_valid_r <= 1'b0;
         rsp_rdata_r <= 8'h00;
         rsp_ref_r <= 1'b0;
         safe_r <= 1'b0;
         rst_r <= 1'b0;
         st_run_r <= 1'b0;
         ssm_r <= 1'b0;
         crc_r <= 1'b0;
         wdm_r <= 1'b0;
         esm_r <= 1'b0;
      end else begin
         cfg_a_r <= cfg_a_nxt;
         cfg_b_r <= cfg_b_nxt;
         rsp_valid_r <= rsp_valid_nxt;
         rsp_rdata_r <= rsp_rdata_nxt;
         rsp_ref_r <= rsp_ref_nxt;
         safe_r <= safe_nxt;
         rst_r <= rst_nxt;
         st_run_r <= st_run_nxt;
         ssm_r <= cfg_b_r[`SRSP_B_SSM];
         crc_r <= cfg_b_r[`SRSP_B_SPI_CRC];
         wdm_r <= cfg_b_r[`SRSP_B_WD_MODE];
         esm_r <= cfg_b_r[`SRSP_B_ESM_MODE];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs straight from flops
   assign rsp_valid_o = rsp_valid_r;
   assign rsp_rdata_o = rsp_rdata_r;
   assign rsp_refused_o = rsp_ref_r;
   assign go_safe_o = safe_r;
   assign go_reset_o = rst_r;
   assign self_test_run_o = st_run_r;
   assign spread_spectrum_enable_o = ssm_r;
   assign spi_crc_enable_o = crc_r;
   assign watchdog_answer_mode_o = wdm_r;
   assign error_monitor_mode_o = esm_r;
   assign crc_image_o = {cfg_b_r, cfg_a_r};

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);

   logic da; // diagnostic or active
   assign da = (dev_state_i == SRSP_ST_DIAG) || (dev_state_i == SRSP_ST_ACTIVE);

   sequence s_no_rst_cause;
      !(reset_output_pin_err_i && cfg_a_r[`SRSP_A_RES_RST]) && !wd_fail_th_i && !esm_fail_th_i;
   endsequence
   sequence s_locked_wr;
      cmd_valid_i && cmd_write_i && (dev_state_i != SRSP_ST_DIAG || cfg_lock_i);
   endsequence

   // self-test start follows the disable bit at reset entry
   chk_self_test_run: assert property (
      reset_entry_i && !cfg_a_r[`SRSP_A_ST_DIS] |=> self_test_run_o)
      else $error("self-test not started");
   chk_self_test_skip: assert property (
      cfg_a_r[`SRSP_A_ST_DIS] |=> !self_test_run_o)
      else $error("self-test started while disabled");
   // safe causes, only from diagnostic or active
   chk_analog_self_test_safe: assert property (
      da && analog_self_test_fail_i && cfg_a_r[`SRSP_A_ST_FAIL] && !endrv_err_i && !reset_output_pin_err_i
      ##0 s_no_rst_cause |=> go_safe_o && !go_reset_o)
      else $error("self-test failure gave no safe");
   chk_drv_safe: assert property (
      da && endrv_err_i && !cfg_a_r[`SRSP_A_DRV_ERR] && !analog_self_test_fail_i && !reset_output_pin_err_i
      && !wd_fail_th_i && !esm_fail_th_i |=> !go_safe_o)
      else $error("driver fault safe while disabled");
   chk_drv_safe_en: assert property (
      da && endrv_err_i && cfg_a_r[`SRSP_A_DRV_ERR] ##0 s_no_rst_cause
      |=> go_safe_o && !go_reset_o)
      else $error("driver fault gave no safe");
   // reset pin fault, reset outranks safe
   chk_reset_output_pin_reset: assert property (
      reset_output_pin_err_i && cfg_a_r[`SRSP_A_RES_RST] && dev_state_i != SRSP_ST_RESET
      |=> go_reset_o && !go_safe_o)
      else $error("reset pin fault did not reset");
   chk_reset_output_pin_safe: assert property (
      da && reset_output_pin_err_i && cfg_a_r[`SRSP_A_RES_SAFE] ##0 s_no_rst_cause |=> go_safe_o)
      else $error("reset pin fault no safe");
   // refused writes leave register a alone
   chk_locked_write: assert property (
      s_locked_wr |=> rsp_refused_o && cfg_a_r == $past(cfg_a_r))
      else $error("locked write took effect");
   // config outputs follow two edges after an accepted write or a reset entry
   chk_ssm_follow: assert property (
      cmd_valid_i && cmd_write_i && wr_ok && cmd_sel_i == `SRSP_SEL_B && !reset_entry_i
      |=> ##1 spread_spectrum_enable_o == $past(cmd_wdata_i[`SRSP_B_SSM], 2))
      else $error("spread spectrum output wrong");
   chk_crc_follow: assert property (
      cmd_valid_i && cmd_write_i && wr_ok && cmd_sel_i == `SRSP_SEL_B
      |=> ##1 spi_crc_enable_o == $past(cmd_wdata_i[`SRSP_B_SPI_CRC], 2))
      else $error("spi crc output wrong");
   chk_mode_reinit: assert property (
      reset_entry_i |=> ##1 !watchdog_answer_mode_o && !error_monitor_mode_o)
      else $error("modes not reinitialized");
   // threshold selectors pick reset or safe
   chk_wd_select: assert property (
      da && wd_fail_th_i |=> (go_reset_o == $past(cfg_b_r[`SRSP_B_WD_RST]))
      || $past(reset_output_pin_err_i || esm_fail_th_i))
      else $error("watchdog threshold wrong target");
   chk_esm_reset: assert property (
      esm_fail_th_i && cfg_b_r[`SRSP_B_ESM_RST] && dev_state_i != SRSP_ST_RESET
      |=> go_reset_o)
      else $error("error monitor threshold no reset");
   chk_esm_safe: assert property (
      da && esm_fail_th_i && !cfg_b_r[`SRSP_B_ESM_RST] && !wd_fail_th_i
      && !(reset_output_pin_err_i && cfg_a_r[`SRSP_A_RES_RST]) |=> go_safe_o && !go_reset_o)
      else $error("error monitor threshold no safe");
   // reserved positions read as zero
   chk_rsvd_zero: assert property (
      rsp_valid_o |-> ((rsp_rdata_o & `SRSP_A_RSVD) == 8'h00 || $past(cmd_sel_i))
      && ((rsp_rdata_o & `SRSP_B_RSVD) == 8'h00 || !$past(cmd_sel_i)))
      else $error("reserved bit read nonzero");

endmodule // srsp_regs

// ### sim/srsp_mcu_model.sv
// controller model issuing decoded register read and write commands
module srsp_mcu_model (
   // clock
   input wire logic mclk_i,
   // command lines toward the block
   output logic cmd_valid_o,
   output logic cmd_write_o,
   output logic cmd_sel_o,
   output logic [7:0] cmd_wdata_o,
   // answers from the block
   input wire logic rsp_valid_i,
   input wire logic [7:0] rsp_rdata_i,
   input wire logic rsp_refused_i
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////////////////////
   // idle lines at time zero
   initial begin
      cmd_valid_o = 1'h0;
      cmd_write_o = 1'h0;
      cmd_sel_o = 1'h0;
      cmd_wdata_o = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one command; frame crc lives outside, only decoded words here
   task automatic xfer(input logic wr, input logic sel, input logic [7:0] wd,
                       output logic [7:0] rd, output logic refd, output logic ok);
      @(negedge mclk_i);
      cmd_valid_o = 1'h1;
      cmd_write_o = wr;
      cmd_sel_o = sel;
      cmd_wdata_o = wd;
      // taken here, answer stands in the following cycle
      @(posedge mclk_i);
      @(negedge mclk_i);
      // released lines show the inverse of the last value
      cmd_valid_o = 1'h0;
      cmd_write_o = ~wr;
      cmd_sel_o = ~sel;
      cmd_wdata_o = ~wd;
      ok = (rsp_valid_i === 1'h1);
      rd = rsp_rdata_i;
      refd = rsp_refused_i;
   endtask
endmodule // srsp_mcu_model

// ### sim/testbench.sv
// self-checking bench for the safety response configuration registers
module testbench import srsp_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic mclk_i = 1'h0; // 100 MHz clock
   logic rstn_i = 1'h0; // active low reset
   logic cmd_valid, cmd_write, cmd_sel, rsp_valid, rsp_refused;
   logic [7:0] cmd_wdata, rsp_rdata;
   srsp_state_t dev_state = SRSP_ST_DIAG; // driven device state
   logic cfg_lock = 1'h0; // config lock
   logic reset_entry = 1'h0; // reset-state entry pulse
   logic [4:0] flt = 5'h00; // analog_self_test, endrv, reset_output_pin, wd, esm events
   logic go_safe, go_reset, st_run, ssm, spi_crc, wd_mode, esm_mode;
   logic [15:0] crc_image;
   int err_count = 0;
   int tests_run = 0;
   // fault table: cfg a, cfg b, state, events, expected {safe, reset}
   logic [24:0] tab [13] = '{
      {8'h08, 8'h02, 2'b01, 5'b10000, 2'b10},
      {8'h00, 8'h02, 2'b10, 5'b10000, 2'b00},
      {8'h04, 8'h02, 2'b10, 5'b01000, 2'b10},
      {8'h00, 8'h02, 2'b01, 5'b01000, 2'b00},
      {8'h02, 8'h02, 2'b11, 5'b00100, 2'b01},
      {8'h01, 8'h02, 2'b10, 5'b00100, 2'b10},
      {8'h01, 8'h02, 2'b11, 5'b00100, 2'b00},
      {8'h03, 8'h02, 2'b01, 5'b00100, 2'b01},
      {8'h00, 8'h02, 2'b10, 5'b00010, 2'b01},
      {8'h00, 8'h00, 2'b10, 5'b00010, 2'b10},
      {8'h00, 8'h01, 2'b11, 5'b00001, 2'b01},
      {8'h00, 8'h00, 2'b10, 5'b00001, 2'b10},
      {8'h0f, 8'h03, 2'b00, 5'b11111, 2'b00}};

   ////////////////////////////////////////////////////////////////////////////
   // clock
   initial begin
      forever #5 mclk_i = ~mclk_i;
   end

   srsp_regs dut_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid),
      .cmd_write_i(cmd_write), .cmd_sel_i(cmd_sel), .cmd_wdata_i(cmd_wdata),
      .rsp_valid_o(rsp_valid), .rsp_rdata_o(rsp_rdata), .rsp_refused_o(rsp_refused),
      .dev_state_i(dev_state), .cfg_lock_i(cfg_lock), .reset_entry_i(reset_entry),
      .analog_self_test_fail_i(flt[4]), .endrv_err_i(flt[3]), .reset_output_pin_err_i(flt[2]),
      .wd_fail_th_i(flt[1]), .esm_fail_th_i(flt[0]), .go_safe_o(go_safe),
      .go_reset_o(go_reset), .self_test_run_o(st_run),
      .spread_spectrum_enable_o(ssm), .spi_crc_enable_o(spi_crc),
      .watchdog_answer_mode_o(wd_mode), .error_monitor_mode_o(esm_mode),
      .crc_image_o(crc_image));

   srsp_mcu_model mcu_u (.mclk_i(mclk_i), .cmd_valid_o(cmd_valid),
      .cmd_write_o(cmd_write), .cmd_sel_o(cmd_sel), .cmd_wdata_o(cmd_wdata),
      .rsp_valid_i(rsp_valid), .rsp_rdata_i(rsp_rdata), .rsp_refused_i(rsp_refused));

   ////////////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // single comparison
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one command through the model, answer judged
   task automatic cmd(input logic wr, input logic sel, input logic [7:0] wd,
                      input logic [7:0] ex, input logic exr);
      logic [7:0] rd;
      logic rf;
      logic ok;
      mcu_u.xfer(wr, sel, wd, rd, rf, ok);
      chk("answer strobe", {15'h0000, ok}, 16'h0001);
      if (!ok) begin
         close_out();
      end
      chk("read data", {8'h00, rd}, {8'h00, ex});
      chk("refused", {15'h0000, rf}, {15'h0000, exr});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // reset values of both registers and outputs
   task automatic t_reset();
      chk("image", crc_image, 16'h0200);
      chk("requests", {13'h0000, go_safe, go_reset, st_run}, 16'h0000);
      chk("modes", {12'h000, ssm, spi_crc, wd_mode, esm_mode}, 16'h0000);
      cmd(1'h0, 1'h0, 8'h00, 8'h00, 1'h0);
      cmd(1'h0, 1'h1, 8'h00, 8'h02, 1'h0);
      $display("test reset done");
   endtask

   // all ones written, reserved bits stay zero, modes follow
   task automatic t_write();
      cmd(1'h1, 1'h0, 8'hff, 8'hbf, 1'h0);
      cmd(1'h1, 1'h1, 8'hff, 8'h5f, 1'h0);
      @(negedge mclk_i);
      chk("modes", {12'h000, ssm, spi_crc, wd_mode, esm_mode}, 16'h000f);
      chk("image", crc_image, 16'h5fbf);
      $display("test write done");
   endtask

   // writes refused when locked or outside diagnostic
   task automatic t_refuse();
      cfg_lock = 1'h1;
      cmd(1'h1, 1'h0, 8'h00, 8'hbf, 1'h1);
      cfg_lock = 1'h0;
      dev_state = SRSP_ST_ACTIVE;
      cmd(1'h1, 1'h1, 8'h00, 8'h5f, 1'h1);
      dev_state = SRSP_ST_DIAG;
      cmd(1'h0, 1'h0, 8'h00, 8'hbf, 1'h0);
      $display("test refuse done");
   endtask

   // fault events against enables and states
   task automatic t_faults();
      for (int i = 0; i < 13; i++) begin
         dev_state = SRSP_ST_DIAG;
         cmd(1'h1, 1'h0, tab[i][24:17], tab[i][24:17], 1'h0);
         cmd(1'h1, 1'h1, tab[i][16:9], tab[i][16:9], 1'h0);
         dev_state = srsp_state_t'(tab[i][8:7]);
         flt = tab[i][6:2];
         @(negedge mclk_i);
         chk("safe reset", {14'h0000, go_safe, go_reset}, {14'h0000, tab[i][1:0]});
         flt = 5'h00;
      end
      dev_state = SRSP_ST_DIAG;
      $display("test faults done");
   endtask

   // reset entry: self-test start and mode bits restored
   task automatic t_entry();
      cmd(1'h1, 1'h0, 8'h00, 8'h00, 1'h0);
      cmd(1'h1, 1'h1, 8'h5f, 8'h5f, 1'h0);
      reset_entry = 1'h1;
      @(negedge mclk_i);
      reset_entry = 1'h0;
      chk("self test", {15'h0000, st_run}, 16'h0001);
      chk("image b", {8'h00, crc_image[15:8]}, 16'h0052);
      @(negedge mclk_i);
      chk("modes", {14'h0000, wd_mode, esm_mode}, 16'h0000);
      cmd(1'h1, 1'h0, 8'h10, 8'h10, 1'h0);
      reset_entry = 1'h1;
      @(negedge mclk_i);
      reset_entry = 1'h0;
      chk("self test", {15'h0000, st_run}, 16'h0000);
      $display("test entry done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (2) @(posedge mclk_i);
      @(negedge mclk_i);
      rstn_i = 1'h1;
      t_reset();
      t_write();
      t_refuse();
      t_faults();
      t_entry();
      close_out();
   end
endmodule // testbench
